//--- hw/ssd_pkg.sv
package ssd_pkg;
	// sync assertion count at which osc and lmfc resets begin
	localparam logic [1:0] SYNC_CNT_ARM = 2'h3;
	localparam logic [1:0] SYNC_CNT_ONE = 2'h1;
	localparam int CLK_MHZ = 200;
	// refill length of the decimation filters after an osc switch
	localparam int FLUSH_CYCLES_DFLT = 64;

	// down-converter configuration
	typedef enum logic [1:0] {
		SSD_SINGLE,
		SSD_DUAL,
		SSD_WIDE
	} ssd_mode_t;

	// lmfs / decimation format
	typedef enum logic [1:0] {
		SSD_FMT_BYP20,
		SSD_FMT_BYP4,
		SSD_FMT_DEC
	} ssd_fmt_t;

	// sync control bits from host
	typedef struct packed {
		logic divider_sync_mask;
		logic osc_frame_sync_mask;
		logic sync_input_powerdown;
		logic software_sync_pulse_bit;
	} ssd_sync_ctl_t;

	// sync reset strobes to the datapath
	typedef struct packed {
		logic div_reset;
		logic osc_reset;
		logic lmfc_reset;
	} ssd_sync_out_t;

	// per-channel chain enables
	typedef struct packed {
		logic chain0_en;
		logic chain1_en;
	} ssd_chain_en_t;
endpackage

//--- hw/ssd_sync_ddc_ctrl.sv
// Notes on behaviour
// R01 - after first sync pulse, source waits over 40 us before the second
// R02 - divider sync mask set blocks sync from the sample-clock divider
// R03 - osc phase and lmfc counter reset from the third sync pulse onward
// R04 - osc/frame sync mask set stops sync to oscillators and framer
// R05 - sync input power-down bit turns off the sync input buffer
// R06 - periodic sync: host waits 40 us plus two periods before masking
// R07 - periodic sync frequency is lmfc frequency over a positive integer
// R08 - sync frequency is a multiple of sample clock over 64
// R09 - lmfc divide is 20K, 4K or D*S*K by format
// R10 - periodic sync preferably kept below 5 MHz
// R11 - source stops sync once the link is synchronised
// R12 - receiver mode single or dual band, or wide observation mode
// R13 - each channel feeds two chains, each with a 16-bit oscillator
// R14 - exactly one of single, dual or wide configurations is active
// R15 - three osc frequencies held, switched by host or gpio
// R16 - optional complex-to-real output at twice rate, shifted quarter rate
// R17 - in receiver mode both chains share one decimation setting
// R18 - decimation setting sets lane rate and number of active lanes
// R19 - observation mode uses one chain with up to three oscillators
// R20 - all three oscillators run continuously whether selected or not
// R21 - output invalid after osc switch until filters fully refilled
// R22 - sync asserted by pin rising edge or software bit 0-to-1
// R23 - sync sampled on clock rising edge; each assertion resets divider
// R24 - assertion counter saturates at three; then forwards to osc, lmfc
module ssd_sync_ddc_ctrl #(
	parameter int OSC_W = 16,
	parameter int FLUSH_CYCLES = ssd_pkg::FLUSH_CYCLES_DFLT,
	parameter int FLUSH_W = 12
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// sync input pin and control bits
	input wire logic i_sync_pin,
	input wire ssd_pkg::ssd_sync_ctl_t i_sync_ctl,
	// down-converter configuration
	input wire ssd_pkg::ssd_mode_t i_mode,
	input wire ssd_pkg::ssd_fmt_t i_fmt,
	input wire logic [4:0] i_decim,
	input wire logic [3:0] i_spf,
	input wire logic [5:0] i_frames_k,
	input wire logic i_real_out,
	input wire logic [2:0][OSC_W-1:0] i_osc_fcw,
	// oscillator selection from host and gpio
	input wire logic [1:0] i_osc_sel_host,
	input wire logic [1:0] i_osc_sel_gpio,
	input wire logic i_gpio_sel_en,
	// sync strobes and status
	output ssd_pkg::ssd_sync_out_t o_sync,
	output logic [1:0] o_sync_count,
	output logic o_sync_buf_en,
	// down-converter control outputs
	output ssd_pkg::ssd_chain_en_t o_chain_en,
	output logic [4:0] o_chain0_decim,
	output logic [4:0] o_chain1_decim,
	output logic [1:0] o_osc_sel,
	output logic [2:0][OSC_W-1:0] o_osc_phase,
	output logic o_real_out,
	output logic [OSC_W-1:0] o_mix_fcw,
	output logic o_data_valid,
	output logic [12:0] o_lmfc_div,
	output logic [2:0] o_lanes
);
	// sync pin synchroniser, edge history and counters
	logic sync_s1_r, sync_s2_r, sync_prev_r, sw_prev_r;
	logic [1:0] cnt_r, cnt_nxt;
	logic [1:0] sel_r;
	logic [FLUSH_W-1:0] flush_r;
	logic [2:0][OSC_W-1:0] phase_r;
	ssd_pkg::ssd_sync_out_t sync_r;

	// lmfc divide per format
	function automatic logic [12:0] lmfc_div(input ssd_pkg::ssd_fmt_t f,
		input logic [4:0] d, input logic [3:0] s, input logic [5:0] k);
		logic [12:0] kk;
		kk = {7'h00, k};
		unique case (f)
			ssd_pkg::SSD_FMT_BYP20: lmfc_div = 13'(kk * 13'h014); // [R09]
			ssd_pkg::SSD_FMT_BYP4: lmfc_div = 13'(kk * 13'h004); // [R09]
			default: lmfc_div = 13'(kk * {8'h00, d} * {9'h000, s}); // [R09]
		endcase
	endfunction

	// sync detection and gating
	wire pin_rise = sync_s2_r & ~sync_prev_r &
		~i_sync_ctl.sync_input_powerdown; // [R22] [R05]
	wire sw_rise = i_sync_ctl.software_sync_pulse_bit & ~sw_prev_r; // [R22]
	wire sync_ev = pin_rise | sw_rise;
	wire armed = (cnt_r == ssd_pkg::SYNC_CNT_ARM); // [R24]
	wire at_two = (cnt_r == ssd_pkg::SYNC_CNT_ARM - ssd_pkg::SYNC_CNT_ONE);
	wire third_or_more = armed | at_two; // [R03] this event makes count 3
	wire fwd = sync_ev & third_or_more &
		~i_sync_ctl.osc_frame_sync_mask; // [R04] [R03]
	wire div_rst = sync_ev & ~i_sync_ctl.divider_sync_mask; // [R23] [R02]
	assign cnt_nxt = (sync_ev & ~armed) ? cnt_r + ssd_pkg::SYNC_CNT_ONE :
		cnt_r; // [R24]

	// mode decoding
	wire is_wide = (i_mode == ssd_pkg::SSD_WIDE);
	wire is_dual = (i_mode == ssd_pkg::SSD_DUAL);
	wire [1:0] sel_req = i_gpio_sel_en ? i_osc_sel_gpio : i_osc_sel_host;
	wire [1:0] sel_ok = (sel_req == 2'h3) ? sel_r : sel_req; // [R15]
	wire sel_chg = (sel_ok != sel_r);
	wire [FLUSH_W-1:0] flush_len = FLUSH_W'(FLUSH_CYCLES);
	wire [12:0] div_nxt = lmfc_div(i_fmt, i_decim, i_spf, i_frames_k);

	// lanes: four in bypass or at low decimation, two mid, one high
	function automatic logic [2:0] lane_count(input ssd_pkg::ssd_fmt_t f,
		input logic [4:0] d);
		if (f != ssd_pkg::SSD_FMT_DEC) lane_count = 3'h4;
		else if (d < 5'h08) lane_count = 3'h4;
		else if (d < 5'h10) lane_count = 3'h2;
		else lane_count = 3'h1;
	endfunction

	wire [2:0] lanes_nxt = lane_count(i_fmt, i_decim); // [R18]

	// two-flop synchroniser and edge history
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			sync_s1_r <= 1'b0;
			sync_s2_r <= 1'b0;
			sync_prev_r <= 1'b0;
			sw_prev_r <= 1'b0;
		end else begin
			sync_s1_r <= i_sync_pin;
			sync_s2_r <= sync_s1_r; // [R23]
			sync_prev_r <= sync_s2_r;
			sw_prev_r <= i_sync_ctl.software_sync_pulse_bit;
		end
	end

	// assertion counter and registered reset strobes
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cnt_r <= 2'h0;
			sync_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			sync_r <= '{div_reset: div_rst, osc_reset: fwd, lmfc_reset: fwd};
		end
	end

	// free-running oscillator phases, reset by forwarded sync
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			phase_r <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				phase_r[i] <= fwd ? '0 : phase_r[i] + i_osc_fcw[i]; // [R20] [R03]
			end
		end
	end

	// oscillator selection and flush counter
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			sel_r <= 2'h0;
			flush_r <= '0;
		end else begin
			sel_r <= sel_ok; // [R15]
			if (sel_chg) flush_r <= flush_len; // [R21]
			else if (flush_r != '0) flush_r <= flush_r - 1'b1;
		end
	end

	// chain enables: one configuration only; wide uses chain 1 alone
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_chain_en <= '0;
		end else begin
			o_chain_en <= '{chain0_en: ~is_wide,
				chain1_en: is_wide | is_dual}; // [R12] [R13] [R14] [R19]
		end
	end

	// both chains of a channel share one decimation setting
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_chain0_decim <= 5'h00;
			o_chain1_decim <= 5'h00;
		end else begin
			o_chain0_decim <= i_decim; // [R17]
			o_chain1_decim <= i_decim; // [R17]
		end
	end

	// complex-to-real output option
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_real_out <= 1'b0;
		end else begin
			o_real_out <= i_real_out; // [R16]
		end
	end

	// mixer word and validity while the filters refill
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_mix_fcw <= '0;
			o_data_valid <= 1'b0;
		end else begin
			o_mix_fcw <= i_osc_fcw[sel_r]; // [R15]
			o_data_valid <= (flush_r == '0) & ~sel_chg; // [R21]
		end
	end

	// lmfc ratio and lane count follow the format
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_lmfc_div <= 13'h0000;
			o_lanes <= 3'h0;
		end else begin
			o_lmfc_div <= div_nxt; // [R09]
			o_lanes <= lanes_nxt; // [R18]
		end
	end

	// sync input buffer enable
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_sync_buf_en <= 1'b0;
		end else begin
			o_sync_buf_en <= ~i_sync_ctl.sync_input_powerdown; // [R05]
		end
	end

	assign o_sync = sync_r;
	assign o_sync_count = cnt_r;
	assign o_osc_sel = sel_r;
	assign o_osc_phase = phase_r;
endmodule

//--- testbench/ssd_sync_ddc_ctrl_sva.sv
// watches the sync strobes and down-converter controls at the ports
module ssd_sync_ddc_ctrl_sva (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire ssd_pkg::ssd_sync_ctl_t i_sync_ctl,
	input wire ssd_pkg::ssd_mode_t i_mode,
	input wire ssd_pkg::ssd_sync_out_t o_sync,
	input wire logic [1:0] o_sync_count,
	input wire logic o_sync_buf_en,
	input wire ssd_pkg::ssd_chain_en_t o_chain_en,
	input wire logic [4:0] o_chain0_decim,
	input wire logic [4:0] o_chain1_decim,
	input wire logic [1:0] o_osc_sel,
	input wire logic o_data_valid
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_div_mask_blocks: assert property (
		i_sync_ctl.divider_sync_mask && $past(i_sync_ctl.divider_sync_mask)
		|-> !o_sync.div_reset) else $error("divider reset while masked");
	a_osc_mask_blocks: assert property (
		$past(i_sync_ctl.osc_frame_sync_mask) |-> !o_sync.osc_reset &&
		!o_sync.lmfc_reset) else $error("osc reset while masked");
	a_osc_needs_three: assert property (
		o_sync.osc_reset |-> o_sync_count == ssd_pkg::SYNC_CNT_ARM)
		else $error("osc reset before third sync");
	a_osc_lmfc_pair: assert property (
		o_sync.osc_reset == o_sync.lmfc_reset) else $error("osc lmfc split");
	a_third_forwards: assert property (
		o_sync.div_reset && o_sync_count == 2'h3 &&
		!i_sync_ctl.osc_frame_sync_mask &&
		!$past(i_sync_ctl.osc_frame_sync_mask) |-> o_sync.osc_reset)
		else $error("armed sync not forwarded");
	a_count_saturates: assert property (
		$past(o_sync_count) == 2'h3 |-> o_sync_count == 2'h3)
		else $error("count left saturation");
	a_buf_follows_pd: assert property (
		$past(i_rst_n, 2) && $past(i_rst_n) |->
		o_sync_buf_en == !$past(i_sync_ctl.sync_input_powerdown))
		else $error("sync buffer enable wrong");
	a_wide_one_chain: assert property (
		$past(i_rst_n, 2) && $past(i_rst_n) &&
		$past(i_mode) == ssd_pkg::SSD_WIDE |-> o_chain_en == 2'h1)
		else $error("wide mode chain enables wrong");
	a_decim_shared: assert property (
		o_chain0_decim == o_chain1_decim) else $error("chain decim differ");
	a_switch_invalid: assert property (
		$changed(o_osc_sel) |-> !o_data_valid)
		else $error("data valid at osc switch");
endmodule
bind ssd_sync_ddc_ctrl ssd_sync_ddc_ctrl_sva i_sva (.i_core_clk, .i_rst_n,
	.i_sync_ctl, .i_mode, .o_sync, .o_sync_count, .o_sync_buf_en,
	.o_chain_en, .o_chain0_decim, .o_chain1_decim, .o_osc_sel, .o_data_valid);

//--- testbench/ssd_src_model.sv
// external sync source: one pulse per request
module ssd_src_model (
	input wire logic i_clk,
	input wire logic i_go,
	output logic o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial o_pin = 1'b0;
	// pulse three cycles high, then the line rests low
	always @(posedge i_clk) if (i_go) begin
		o_pin <= #1 1'b1;
		repeat (3) @(posedge i_clk);
		o_pin <= #1 1'b0;
	end
endmodule

//--- testbench/ssd_sync_ddc_ctrl_test.sv
module ssd_sync_ddc_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 0, i_rst_n = 0, go = 0, i_sync_pin, i_real_out = 0;
	logic i_gpio_sel_en = 0, o_sync_buf_en, o_data_valid, o_real_out;
	ssd_pkg::ssd_sync_ctl_t i_sync_ctl = '0;
	ssd_pkg::ssd_mode_t i_mode = ssd_pkg::SSD_SINGLE;
	ssd_pkg::ssd_fmt_t i_fmt = ssd_pkg::SSD_FMT_DEC;
	logic [4:0] i_decim = 5'h8, o_chain0_decim, o_chain1_decim;
	logic [3:0] i_spf = 4'h1;
	logic [5:0] i_frames_k = 6'h10;
	logic [2:0][15:0] i_osc_fcw, o_osc_phase;
	logic [1:0] i_osc_sel_host = 0, i_osc_sel_gpio = 0, o_sync_count, o_osc_sel;
	ssd_pkg::ssd_sync_out_t o_sync;
	ssd_pkg::ssd_chain_en_t o_chain_en;
	logic [15:0] o_mix_fcw, lf = 16'hcff3, p;
	logic [12:0] o_lmfc_div;
	logic [2:0] o_lanes, q[$];
	int fail_count = 0, checked = 0, n, e;
	ssd_sync_ddc_ctrl #(.FLUSH_CYCLES(4)) i_dut (.*);
	ssd_src_model i_src (.i_clk(i_core_clk), .i_go(go), .o_pin(i_sync_pin));
	initial forever #2.5 i_core_clk = ~i_core_clk;
	function automatic logic [15:0] lfsr(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(logic [15:0] a, logic [15:0] x);
		checked++;
		if (a !== x) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, a, x);
		end
	endtask
	task summarize;
		if (fail_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic step(int c); repeat (c) @(posedge i_core_clk); #1; endtask
	task sw; i_sync_ctl.software_sync_pulse_bit = 1; step(1);
		i_sync_ctl.software_sync_pulse_bit = 0; step(6); endtask
	// pulse train spacing stands for settle time and legal sync rate
	task pn; go = 1; step(1); go = 0; step(8); endtask
	// each div pulse is matched to the oldest noted expectation
	always @(posedge i_core_clk) if (i_rst_n && o_sync.div_reset === 1'b1) begin
		if (q.size() == 0) chk(16'h0, 16'h1);
		else chk({o_sync.osc_reset, o_sync_count}, q.pop_front());
	end
	initial begin #100000; fail_count++; summarize; end
	initial begin
		for (int i = 0; i < 3; i++) begin lf = lfsr(lf); i_osc_fcw[i] = lf; end
		step(20); i_rst_n = 1; step(2);
		q.push_back(3'h1); sw;
		q.push_back(3'h2); pn;
		q.push_back(3'h7); pn;
		q.push_back(3'h7); sw;
		i_sync_ctl.osc_frame_sync_mask = 1; q.push_back(3'h3); pn;
		i_sync_ctl.divider_sync_mask = 1; pn;
		i_sync_ctl = '0; i_sync_ctl.sync_input_powerdown = 1; step(2);
		chk(o_sync_buf_en, 0); pn; i_sync_ctl = '0; step(2);
		chk(o_sync_buf_en, 1); chk(o_sync_count, 3);
		for (int i = 0; i < 3; i++) begin
			i_mode = ssd_pkg::ssd_mode_t'(i); step(3);
			chk(o_chain_en, i == 0 ? 2 : i == 1 ? 3 : 1);
			i_fmt = ssd_pkg::ssd_fmt_t'(i); lf = lfsr(lf);
			i_decim = lf[4:0] | 5'h4; i_spf = 4'h1 + lf[5];
			i_frames_k = {1'b0, lf[10:6]} | 6'h1; step(3);
			chk(o_lmfc_div, i == 0 ? 20 * i_frames_k : i == 1 ? 4 * i_frames_k
				: i_decim * i_spf * i_frames_k);
			chk(o_lanes, (i < 2 || i_decim < 8) ? 4 : i_decim < 16 ? 2 : 1);
			chk(o_chain0_decim, i_decim);
		end
		for (int j = 0; j < 4; j++) begin
			e = j < 3 ? (j + 1) % 3 : 1; n = 0;
			lf = lfsr(lf); i_osc_fcw[e] = lf;
			if (j < 3) i_osc_sel_host = e;
			else begin i_gpio_sel_en = 1; i_osc_sel_gpio = e; end
			repeat (20) begin step(1); if (o_data_valid === 1'b0) n++; end
			chk(n, 5); chk(o_mix_fcw, i_osc_fcw[e]);
		end
		p = o_osc_phase[2]; step(1);
		chk(o_osc_phase[2], p + i_osc_fcw[2]);
		i_real_out = 1; step(2); chk(o_real_out, 1);
		chk(q.size(), 0);
		summarize;
	end
endmodule
